// ===== logic/spc_pkg.sv
// Package: constants for status and program counter registers
// Behaviour
// - Carry bit 15 set on add carry out or subtract without borrow
// - Positive bit 14 set when result above zero
// - Zero bit 13 set when result equals zero
// - Negative bit 12 set when result below zero
// - Processor state bits 7..4 decide privileged instruction legality
// - Address state bits 3..0 drive extended page output
// - Condition codes mirror status bits while enabled, enabled after reset
// - Status word readable and loadable by native I/O
// - 20-bit fetch address from counter, 16-bit instruction words accepted
// - Instruction register is primary plus secondary 16-bit latch
// - One delay-slot instruction executes before the branch target
// - Counter copied to save register on interrupt or branch
// - Native input returns save register contents
// - Prefetched emulated instruction held in readable 16-bit register
// - Current emulated instruction held in its own register
// - Program counter 16 bits, readable and writable by native I/O
`default_nettype none
package spc_pkg;
  localparam int unsigned IA_W = 20;
  localparam int unsigned DW   = 16;
  // Register select codes on the native I/O port
  localparam logic [2:0] SEL_FLAGS = 3'h0;
  localparam logic [2:0] SEL_SAVE  = 3'h1;
  localparam logic [2:0] SEL_PREF  = 3'h2;
  localparam logic [2:0] SEL_CUR   = 3'h3;
  localparam logic [2:0] SEL_PC    = 3'h4;
  localparam logic [2:0] SEL_IC    = 3'h5;
  localparam logic [2:0] SEL_LATCH = 3'h6;
  localparam int unsigned C_BIT = 15;
  localparam int unsigned P_BIT = 14;
  localparam int unsigned Z_BIT = 13;
  localparam int unsigned N_BIT = 12;
  localparam logic [15:0] FLAGS_WMASK = 16'hF0FF;
  localparam logic [15:0] FLAGS_RST   = 16'h0000;
  localparam logic [19:0] IC_RST      = 20'h0_0000;
  localparam logic [19:0] IC_ONE      = 20'h0_0001;
  localparam logic [15:0] W_ZERO      = 16'h0000;
  localparam logic [3:0]  PS_PRIV     = 4'h0;
endpackage
`default_nettype wire

// ===== logic/spc_regs.sv
// Module: status word, instruction counter, latches and emulation registers
`default_nettype none
module spc_regs (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  // Native I/O register port
  input  wire logic        io_wr_i,
  input  wire logic [2:0]  io_sel_i,
  input  wire logic [15:0] io_wdata_i,
  output logic      [15:0] io_rdata_o,
  // ALU result for flag update
  input  wire logic        alu_upd_i,
  input  wire logic [15:0] alu_res_i,
  input  wire logic        alu_sub_i,
  input  wire logic        alu_cout_i,
  // Condition code enable and outputs
  input  wire logic        cc_off_i,
  output logic      [3:0]  cc_o,
  output logic             priv_ok_o,
  output logic      [3:0]  ext_page_o,
  // Instruction memory
  output logic      [19:0] imem_addr_o,
  input  wire logic [15:0] imem_data_i,
  // Sequencing
  input  wire logic        step_i,
  input  wire logic        branch_i,
  input  wire logic        irq_take_i,
  input  wire logic [19:0] target_i,
  output logic      [15:0] exec_word_o,
  // Emulation side
  input  wire logic        emu_pref_i,
  input  wire logic [15:0] emu_word_i,
  input  wire logic        emu_issue_i,
  input  wire logic        emu_pc_inc_i
);
  logic [15:0] flags_r, flags_nxt;
  logic [19:0] ic_r, ic_nxt, save_r, save_nxt, tgt_r, tgt_nxt;
  logic        pend_r, pend_nxt;
  logic [15:0] prim_r, prim_nxt, sec_r, sec_nxt;
  logic [15:0] pref_r, pref_nxt, cur_r, cur_nxt, pc_r, pc_nxt;
  logic        cce_r, cce_nxt;
  logic        wr_flags, wr_pc, redirect;

  assign wr_flags = io_wr_i && (io_sel_i == spc_pkg::SEL_FLAGS);
  assign wr_pc    = io_wr_i && (io_sel_i == spc_pkg::SEL_PC);
  assign redirect = branch_i || irq_take_i;

  always_comb begin
    flags_nxt = flags_r;
    if (alu_upd_i) begin
      // Subtract: carry means no borrow, which the ALU reports as cout
      flags_nxt[spc_pkg::C_BIT] = alu_cout_i;
      flags_nxt[spc_pkg::P_BIT] = !alu_res_i[15] && (alu_res_i != spc_pkg::W_ZERO);
      flags_nxt[spc_pkg::Z_BIT] = (alu_res_i == spc_pkg::W_ZERO);
      flags_nxt[spc_pkg::N_BIT] = alu_res_i[15];
    end
    // Software load wins over a same-cycle ALU update
    if (wr_flags) begin
      flags_nxt = io_wdata_i & spc_pkg::FLAGS_WMASK;
    end
    cce_nxt = !cc_off_i;
  end

  always_comb begin
    ic_nxt   = ic_r;
    save_nxt = save_r;
    tgt_nxt  = tgt_r;
    pend_nxt = pend_r;
    prim_nxt = prim_r;
    sec_nxt  = sec_r;
    if (step_i) begin
      prim_nxt = imem_data_i;
      sec_nxt  = prim_r;
      if (pend_r) begin
        ic_nxt   = tgt_r;
        pend_nxt = 1'b0;
      end else begin
        ic_nxt = ic_r + spc_pkg::IC_ONE;
      end
    end
    // Slot instruction fetched before jumping keeps the delayed branch
    if (redirect) begin
      save_nxt = ic_r;
      tgt_nxt  = target_i;
      pend_nxt = 1'b1;
    end
  end

  always_comb begin
    pref_nxt = emu_pref_i ? emu_word_i : pref_r;
    cur_nxt  = emu_issue_i ? pref_r : cur_r;
    pc_nxt   = pc_r;
    if (emu_pc_inc_i) begin
      pc_nxt = pc_r + 16'h0001;
    end
    if (wr_pc) begin
      pc_nxt = io_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      flags_r <= spc_pkg::FLAGS_RST;
      cce_r   <= 1'b1;
      ic_r    <= spc_pkg::IC_RST;
      save_r  <= spc_pkg::IC_RST;
      tgt_r   <= spc_pkg::IC_RST;
      pend_r  <= 1'b0;
      prim_r  <= spc_pkg::W_ZERO;
      sec_r   <= spc_pkg::W_ZERO;
      pref_r  <= spc_pkg::W_ZERO;
      cur_r   <= spc_pkg::W_ZERO;
      pc_r    <= spc_pkg::W_ZERO;
    end else begin
      flags_r <= flags_nxt;
      cce_r   <= cce_nxt;
      ic_r    <= ic_nxt;
      save_r  <= save_nxt;
      tgt_r   <= tgt_nxt;
      pend_r  <= pend_nxt;
      prim_r  <= prim_nxt;
      sec_r   <= sec_nxt;
      pref_r  <= pref_nxt;
      cur_r   <= cur_nxt;
      pc_r    <= pc_nxt;
    end
  end

  // Read mux, 20-bit registers give low 16 bits on the 16-bit port
  always_comb begin
    if (io_sel_i == spc_pkg::SEL_FLAGS) begin
      io_rdata_o = flags_r;
    end else if (io_sel_i == spc_pkg::SEL_SAVE) begin
      io_rdata_o = save_r[15:0];
    end else if (io_sel_i == spc_pkg::SEL_PREF) begin
      io_rdata_o = pref_r;
    end else if (io_sel_i == spc_pkg::SEL_CUR) begin
      io_rdata_o = cur_r;
    end else if (io_sel_i == spc_pkg::SEL_PC) begin
      io_rdata_o = pc_r;
    end else if (io_sel_i == spc_pkg::SEL_IC) begin
      io_rdata_o = ic_r[15:0];
    end else if (io_sel_i == spc_pkg::SEL_LATCH) begin
      io_rdata_o = sec_r;
    end else begin
      io_rdata_o = spc_pkg::W_ZERO;
    end
  end

  assign cc_o        = cce_r ? flags_r[15:12] : 4'h0;
  assign priv_ok_o   = (flags_r[7:4] == spc_pkg::PS_PRIV);
  assign ext_page_o  = flags_r[3:0];
  assign imem_addr_o = ic_r;
  assign exec_word_o = sec_r;

  // Flag updates from the ALU

  zero_flag_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    alu_upd_i && !wr_flags |=> cc_o[1] == ($past(alu_res_i) == 16'h0000) || !cce_r)
    else $error("zero flag wrong");
  neg_flag_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    alu_upd_i && !wr_flags |=> flags_r[12] == $past(alu_res_i[15]))
    else $error("negative flag wrong");
  pos_flag_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    alu_upd_i && !wr_flags |=> !(flags_r[14] && flags_r[13]))
    else $error("positive and zero both set");
  carry_flag_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    alu_upd_i && !wr_flags |=> flags_r[15] == $past(alu_cout_i))
    else $error("carry flag wrong");
  pos_val_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    alu_upd_i && !wr_flags |=>
      flags_r[14] == (!$past(alu_res_i[15]) && ($past(alu_res_i) != spc_pkg::W_ZERO)))
    else $error("positive flag wrong");
  zero_val_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    alu_upd_i && !wr_flags |=> flags_r[13] == ($past(alu_res_i) == spc_pkg::W_ZERO))
    else $error("zero flag value wrong");
  carry_sub_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    alu_upd_i && alu_sub_i && !wr_flags |=> flags_r[15] == $past(alu_cout_i))
    else $error("subtract carry wrong");
  flags_hold_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !alu_upd_i && !wr_flags |=> $stable(flags_r))
    else $error("flags changed with no update");

  // Software load and read port
  flags_load_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    wr_flags |=> flags_r == ($past(io_wdata_i) & spc_pkg::FLAGS_WMASK))
    else $error("flags load wrong");
  rsvd_store_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    flags_r[11:8] == 4'h0)
    else $error("reserved bits stored");
  rsvd_zero_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    io_sel_i == spc_pkg::SEL_FLAGS |-> io_rdata_o[11:8] == 4'h0)
    else $error("reserved bits not zero");
  flags_read_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    io_sel_i == spc_pkg::SEL_FLAGS |-> io_rdata_o == flags_r)
    else $error("flags read wrong");
  save_read_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    io_sel_i == spc_pkg::SEL_SAVE |-> io_rdata_o == save_r[15:0])
    else $error("save read wrong");
  pref_read_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    io_sel_i == spc_pkg::SEL_PREF |-> io_rdata_o == pref_r)
    else $error("prefetch read wrong");
  cur_read_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    io_sel_i == spc_pkg::SEL_CUR |-> io_rdata_o == cur_r)
    else $error("current read wrong");
  pc_read_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    io_sel_i == spc_pkg::SEL_PC |-> io_rdata_o == pc_r)
    else $error("program counter read wrong");
  ic_read_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    io_sel_i == spc_pkg::SEL_IC |-> io_rdata_o == ic_r[15:0])
    else $error("counter read wrong");
  latch_read_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    io_sel_i == spc_pkg::SEL_LATCH |-> io_rdata_o == sec_r)
    else $error("latch read wrong");
  spare_sel_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    io_sel_i == 3'h7 |-> io_rdata_o == spc_pkg::W_ZERO)
    else $error("spare select not zero");

  // Condition codes and state fields
  cc_mirror_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    cce_r |-> cc_o == flags_r[15:12])
    else $error("condition codes not mirrored");
  cc_off_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !cce_r |-> cc_o == 4'h0)
    else $error("condition codes not off");
  cc_dis_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    cc_off_i |=> !cce_r)
    else $error("code enable not dropped");
  cc_en_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !cc_off_i |=> cce_r)
    else $error("code enable not raised");
  priv_deny_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    wr_flags && (io_wdata_i[7:4] != spc_pkg::PS_PRIV) |=> !priv_ok_o)
    else $error("privilege granted wrongly");
  priv_grant_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    wr_flags && (io_wdata_i[7:4] == spc_pkg::PS_PRIV) |=> priv_ok_o)
    else $error("privilege denied wrongly");
  page_out_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    wr_flags |=> ext_page_o == $past(io_wdata_i[3:0]))
    else $error("page output wrong");
  page_track_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ext_page_o == flags_r[3:0])
    else $error("page output not tracking");

  // Fetch counter and latch pair
  fetch_addr_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    imem_addr_o == ic_r)
    else $error("fetch address wrong");
  ic_inc_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    step_i && !pend_r |=> ic_r == $past(ic_r) + spc_pkg::IC_ONE)
    else $error("counter not advanced");
  ic_hold_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !step_i |=> $stable(ic_r))
    else $error("counter moved without step");
  prim_load_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    step_i |=> prim_r == $past(imem_data_i))
    else $error("primary latch missed word");
  sec_load_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    step_i |=> sec_r == $past(prim_r))
    else $error("secondary latch missed word");
  latch_hold_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !step_i |=> $stable(prim_r) && $stable(sec_r))
    else $error("latches moved without step");
  latch_shift_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    step_i ##1 step_i |=> exec_word_o == $past(imem_data_i, 2))
    else $error("latch pair not shifting");
  word_out_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    exec_word_o == sec_r)
    else $error("executed word wrong");

  // Redirect, delay slot and save
  save_copy_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    redirect |=> save_r == $past(ic_r))
    else $error("save register missed counter");
  save_hold_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !redirect |=> $stable(save_r))
    else $error("save register changed");
  pend_set_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    redirect |=> pend_r)
    else $error("redirect not armed");
  pend_clr_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    step_i && !redirect |=> !pend_r)
    else $error("pending redirect kept");
  pend_hold_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !step_i && !redirect |=> $stable(pend_r))
    else $error("pending flag changed");
  tgt_cap_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    redirect |=> tgt_r == $past(target_i))
    else $error("target not captured");
  tgt_hold_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !redirect |=> $stable(tgt_r))
    else $error("target changed");
  jump_step_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    step_i && pend_r |=> ic_r == $past(tgt_r))
    else $error("jump to target missed");
  delay_slot_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    redirect && !step_i ##1 (step_i && !redirect) |=> imem_addr_o == $past(tgt_r))
    else $error("branch target not taken after slot");

  // Emulation registers
  pref_load_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    emu_pref_i |=> pref_r == $past(emu_word_i))
    else $error("prefetch not loaded");
  pref_hold_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !emu_pref_i |=> $stable(pref_r))
    else $error("prefetch changed");
  cur_load_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    emu_issue_i |=> cur_r == $past(pref_r))
    else $error("current not issued");
  cur_hold_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !emu_issue_i |=> $stable(cur_r))
    else $error("current changed");
  pc_write_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    wr_pc |=> pc_r == $past(io_wdata_i))
    else $error("program counter write lost");
  pc_inc_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    emu_pc_inc_i && !wr_pc |=> pc_r == $past(pc_r) + 16'h0001)
    else $error("program counter not advanced");
  pc_hold_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !emu_pc_inc_i && !wr_pc |=> $stable(pc_r))
    else $error("program counter changed");
  pc_wins_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    wr_pc && emu_pc_inc_i |=> pc_r == $past(io_wdata_i))
    else $error("increment beat software write");
endmodule // spc_regs
`default_nettype wire

// ===== test/spc_imem.sv
// Partner model: native instruction memory
`default_nettype none
module spc_imem (
  // Fetch port
  input  wire logic [19:0] addr_i,
  output logic      [15:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Word differs per address among addresses with equal bits 19..16, so a stale or wrong fetch there shows at once
  assign data_o = addr_i[15:0] ^ {addr_i[19:16], 12'h5A5};
endmodule // spc_imem
`default_nettype wire

// ===== test/status_and_program_counter_regs_test.sv
// Testbench: status word, counters, latches and emulation registers
`default_nettype none
module status_and_program_counter_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_i = 1'b0, nrst_i = 1'b0, io_wr_i = 1'b0, alu_upd_i = 1'b0;
  logic        alu_sub_i = 1'b0, alu_cout_i = 1'b0, cc_off_i = 1'b0, step_i = 1'b0;
  logic        branch_i = 1'b0, irq_take_i = 1'b0, emu_pref_i = 1'b0, emu_issue_i = 1'b0;
  logic        emu_pc_inc_i = 1'b0, priv_ok_o;
  logic [2:0]  io_sel_i = 3'h0;
  logic [15:0] io_wdata_i = 16'h0000, alu_res_i = 16'h0000, emu_word_i = 16'h0000;
  logic [15:0] io_rdata_o, exec_word_o, imem_data, w;
  logic [3:0]  cc_o, ext_page_o;
  logic [19:0] imem_addr_o, t, s, target_i = 20'h0_0000;
  logic [22:0] q[$], e;
  logic [31:0] rnd = 32'h0000_4f55;
  logic [15:0] res_tab [4] = '{16'h0000, 16'h0005, 16'h8000, 16'h7FFF};
  int          err_total = 0, n_tests = 0;

  spc_regs u_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .io_wr_i(io_wr_i),
    .io_sel_i(io_sel_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .alu_upd_i(alu_upd_i), .alu_res_i(alu_res_i), .alu_sub_i(alu_sub_i),
    .alu_cout_i(alu_cout_i), .cc_off_i(cc_off_i), .cc_o(cc_o), .priv_ok_o(priv_ok_o),
    .ext_page_o(ext_page_o), .imem_addr_o(imem_addr_o), .imem_data_i(imem_data),
    .step_i(step_i), .branch_i(branch_i), .irq_take_i(irq_take_i), .target_i(target_i),
    .exec_word_o(exec_word_o), .emu_pref_i(emu_pref_i), .emu_word_i(emu_word_i),
    .emu_issue_i(emu_issue_i), .emu_pc_inc_i(emu_pc_inc_i));
  spc_imem u_mem (.addr_i(imem_addr_o), .data_o(imem_data));

  always #2.5 core_clk_i = ~core_clk_i;

  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [19:0] mw(input logic [19:0] a);
    return {4'h0, a[15:0] ^ {a[19:16], 12'h5A5}};
  endfunction
  task automatic cyc;
    @(posedge core_clk_i);
    #1;
  endtask
  // Note the expectation; the watcher compares it at the next falling edge
  task automatic exp(input logic [2:0] k, input logic [2:0] sl, input logic [19:0] v);
    io_sel_i = sl;
    q.push_back({k, v});
    cyc;
  endtask
  task automatic wr(input logic [2:0] sl, input logic [15:0] d);
    io_sel_i = sl;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    cyc;
    io_wr_i = 1'b0;
  endtask
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(negedge core_clk_i) begin
    if (q.size() > 0) begin
      e = q.pop_front();
      case (e[22:20])
        3'h0: s = {4'h0, io_rdata_o};
        3'h1: s = {16'h0000, cc_o};
        3'h2: s = imem_addr_o;
        3'h3: s = {4'h0, exec_word_o};
        default: s = {15'h0000, priv_ok_o, ext_page_o};
      endcase
      n_tests++;
      if (s !== e[19:0]) begin
        err_total++;
        $display("MISMATCH kind %0d sel %0d expected %h seen %h", e[22:20], io_sel_i, e[19:0], s);
      end
    end
  end

  initial begin
    #20000;
    err_total++;
    finish_test;
  end

  initial begin
    repeat (8) cyc;
    nrst_i = 1'b1;
    for (int i = 0; i < 8; i++) exp(3'h0, i[2:0], 20'h0_0000);
    exp(3'h1, 3'h0, 20'h0_0000);
    for (int i = 0; i < 4; i++) begin
      rnd = nx(rnd);
      w = (i == 0) ? 16'hFF0A : rnd[15:0];
      wr(3'h0, w);
      exp(3'h0, 3'h0, {4'h0, w & 16'hF0FF});
      exp(3'h1, 3'h0, {16'h0000, w[15:12]});
      exp(3'h4, 3'h0, {15'h0000, w[7:4] == 4'h0, w[3:0]});
    end
    for (int i = 0; i < 4; i++) begin
      alu_res_i = res_tab[i];
      alu_cout_i = i[0];
      alu_sub_i = i[1];
      alu_upd_i = 1'b1;
      cyc;
      alu_upd_i = 1'b0;
      exp(3'h1, 3'h0, {16'h0000, i[0], !alu_res_i[15] && alu_res_i != 16'h0000,
        alu_res_i == 16'h0000, alu_res_i[15]});
    end
    cc_off_i = 1'b1;
    cyc;
    exp(3'h1, 3'h0, 20'h0_0000);
    cc_off_i = 1'b0;
    cyc;
    exp(3'h1, 3'h0, 20'h0_000C);
    rnd = nx(rnd);
    wr(3'h4, rnd[15:0]);
    emu_pc_inc_i = 1'b1;
    cyc;
    exp(3'h0, 3'h4, {4'h0, rnd[15:0] + 16'h0001});
    wr(3'h4, 16'h1234);
    emu_pc_inc_i = 1'b0;
    exp(3'h0, 3'h4, 20'h0_1234);
    emu_word_i = rnd[31:16];
    emu_pref_i = 1'b1;
    cyc;
    emu_pref_i = 1'b0;
    exp(3'h0, 3'h2, {4'h0, rnd[31:16]});
    exp(3'h0, 3'h3, 20'h0_0000);
    emu_issue_i = 1'b1;
    cyc;
    emu_issue_i = 1'b0;
    exp(3'h0, 3'h3, {4'h0, rnd[31:16]});
    step_i = 1'b1;
    cyc;
    cyc;
    step_i = 1'b0;
    exp(3'h2, 3'h0, 20'h0_0002);
    exp(3'h3, 3'h6, mw(20'h0_0000));
    exp(3'h0, 3'h6, mw(20'h0_0000));
    t = nx(rnd) >> 12;
    target_i = t;
    branch_i = 1'b1;
    cyc;
    branch_i = 1'b0;
    exp(3'h0, 3'h1, 20'h0_0002);
    exp(3'h2, 3'h5, 20'h0_0002);
    step_i = 1'b1;
    cyc;
    step_i = 1'b0;
    exp(3'h2, 3'h0, t);
    step_i = 1'b1;
    cyc;
    step_i = 1'b0;
    exp(3'h3, 3'h0, mw(20'h0_0002));
    irq_take_i = 1'b1;
    cyc;
    irq_take_i = 1'b0;
    exp(3'h0, 3'h1, {4'h0, t[15:0] + 16'h0001});
    cyc;
    finish_test;
  end
endmodule // status_and_program_counter_regs_test
`default_nettype wire
